/* File: design/fpc_top.sv */
// Flash program control: mapping, keyed launch, sequencer, lock levels
//
// Operation
// - User array read only through code loads
// - Mapped stores below 1000h fill latches
// - Address bits 6-0 byte, 14-7 page
// - Space select maps user, row, security
// - Key 5 then A launches programming
// - A write programs per space select
// - Intervening access aborts the key sequence
// - Busy bit set while programming runs
// - Latches take one to full page
// - Erase then program only loaded bytes
// - Last loaded page is target page
// - Read by mapping, code load, clear
// - Lock bits give three protection levels
// - Lock bits writable only in parallel mode
// - Control fields key, map, space, busy
// - Busy cleared by hardware, not software
// - Security upper nibble software, lower hardware
//
// The address map and the Wishbone interface to the registers were decided locally.
module fpc_top
    import fpc_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int WRITE_CYCLES = WRITE_CYC
) (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             DMEM_WE,
    output logic      [15:0] DMEM_ADDR,
    output logic      [7:0]  DMEM_DATA,
    output logic             PROGRAM_IN_PROGRESS,
    input  wire logic        PP_SEC_WE,
    input  wire logic [3:0]  PP_SEC_LO,
    output logic             PP_WRITE_BLOCK,
    output logic             PP_READ_BLOCK
);
    // --------------------
    // Storage and state
    // --------------------
    logic [7:0]  user_mem_r [USER_BYTES];
    logic [7:0]  boot_info_row_mem_r [PAGE_BYTES];
    logic [7:0]  sec_r;
    logic [3:0]  key_r;
    logic        map_r;
    logic [1:0]  spc_r;
    logic        busy_r;
    logic        armed_r;
    logic [15:0] ptr_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        dwe_r;
    logic [15:0] daddr_r;
    logic [7:0]  ddata_r;
    logic        wblk_r;
    logic        rblk_r;
    fpc_state_e  state_r;
    logic [1:0]  job_r;
    logic [PAGE_AW-1:0] idx_r;
    logic [15:0] cnt_r;
    logic [7:0]  lat_rdata;
    logic        lat_rloaded;
    logic [7:0]  lat_page;

    // --------------------
    // Bus decode
    // --------------------
    logic        take;
    logic        wr_take;
    logic        ctl_wr;
    logic        store_wr;
    logic        latch_hit;
    logic        latch_wr;
    logic        launch;
    logic        last_idx;
    logic [15:0] wait_cyc;
    logic [7:0]  code_byte;

    function automatic logic reg_is(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // Space decode for code loads
    function automatic logic [7:0] code_read(input logic [1:0] spc, input logic [15:0] a,
                                             input logic [7:0] u, input logic [7:0] x,
                                             input logic [7:0] s);
        logic [7:0] v;
        v = ERASED_BYTE;
        case (spc)
            SPC_USER: v = u;
            SPC_BOOT_INFO_ROW: v = (a >= BOOT_INFO_ROW_BASE) ? x : ERASED_BYTE;
            SPC_SEC:  v = (a == SEC_ADDR) ? s : ERASED_BYTE;
            default:  v = ERASED_BYTE;
        endcase
        return v;
    endfunction

    assign take      = WB_CYC_I && WB_STB_I && !ack_r;
    assign wr_take   = take && WB_WE_I && WB_SEL_I[0];
    assign ctl_wr    = wr_take && reg_is(WB_ADR_I, REG_CTRL);
    assign store_wr  = wr_take && reg_is(WB_ADR_I, REG_STORE);
    // Latches answer only while mapped; row addresses accepted too
    assign latch_hit = map_r && (ptr_r <= LATCH_LO_TOP || ptr_r >= BOOT_INFO_ROW_BASE);
    assign latch_wr  = store_wr && latch_hit && !busy_r;
    assign launch    = ctl_wr && armed_r && !busy_r
                       && WB_DAT_I[CTL_KEY_MSB:CTL_KEY_LSB] == KEY_SECOND
                       && WB_DAT_I[CTL_SPC_MSB:CTL_SPC_LSB] != SPC_RSVD;
    assign code_byte = code_read(spc_r, ptr_r, user_mem_r[ptr_r[USER_AW-1:0]],
                                 boot_info_row_mem_r[ptr_r[PAGE_AW-1:0]], sec_r);
    assign last_idx  = (job_r == SPC_SEC) || (idx_r == PAGE_AW'(PAGE_BYTES - 1));
    assign wait_cyc  = (state_r == ST_ERASE) ? 16'(ERASE_CYCLES) : 16'(WRITE_CYCLES);

    // --------------------
    // Column latch buffer
    // --------------------
    fpc_latch #(
        .DEPTH (PAGE_BYTES),
        .AW    (PAGE_AW)
    ) u_latch (
        .clk     (CLK),
        .srst    (SRST),
        .wr      (latch_wr),
        .waddr   (ptr_r[6:0]),
        .wdata   (WB_DAT_I[7:0]),
        .wpage   (ptr_r[14:7]),
        .clear   (state_r != ST_IDLE && state_r != ST_ERASE && last_idx
                  && cnt_r == 16'h0000 || (state_r != ST_IDLE && !lat_rloaded && last_idx
                  && state_r == ST_ERASE)),
        .raddr   (idx_r),
        .rdata   (lat_rdata),
        .rloaded (lat_rloaded),
        .page    (lat_page)
    );

    // --------------------
    // Pin synchroniser for the parallel programmer
    // --------------------
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;
    logic [4:0] pin_raw;
    logic [4:0] pin_q;
    logic       pp_we_d;

    assign pin_raw = {PP_SEC_WE, PP_SEC_LO};

    // Three stages; a change counts once stages two and three agree
    generate
        for (genvar g = 0; g < 5; g++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    pin_s1[g] <= 1'b0;
                    pin_s2[g] <= 1'b0;
                    pin_s3[g] <= 1'b0;
                    pin_q[g]  <= 1'b0;
                end else begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                    if (pin_s2[g] == pin_s3[g]) begin
                        pin_q[g] <= pin_s3[g];
                    end
                end
            end
        end
    endgenerate

    // Edge of the filtered parallel write strobe
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pp_we_d <= 1'b0;
        end else begin
            pp_we_d <= pin_q[4];
        end
    end

    // --------------------
    // Wishbone answer: ack one cycle after the request is taken
    // --------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= take;
            dat_r <= '0;
            if (take && !WB_WE_I) begin
                if (reg_is(WB_ADR_I, REG_CTRL)) begin
                    dat_r[7:0] <= {key_r, map_r, spc_r, busy_r};
                end else if (reg_is(WB_ADR_I, REG_PTR)) begin
                    dat_r[15:0] <= ptr_r;
                end else if (reg_is(WB_ADR_I, REG_LOAD)) begin
                    dat_r[7:0] <= code_byte;
                end else if (reg_is(WB_ADR_I, REG_SEC)) begin
                    dat_r[7:0] <= sec_r;
                end
            end
        end
    end

    // Control fields; busy bit not writable
    always_ff @(posedge CLK) begin
        if (SRST) begin
            key_r <= CTL_RESET[CTL_KEY_MSB:CTL_KEY_LSB];
            map_r <= CTL_RESET[CTL_MAP_BIT];
            spc_r <= CTL_RESET[CTL_SPC_MSB:CTL_SPC_LSB];
        end else if (ctl_wr) begin
            key_r <= WB_DAT_I[CTL_KEY_MSB:CTL_KEY_LSB];
            map_r <= WB_DAT_I[CTL_MAP_BIT];
            spc_r <= WB_DAT_I[CTL_SPC_MSB:CTL_SPC_LSB];
        end
    end

    // Key arming: only a 5 write arms, any other access disarms
    always_ff @(posedge CLK) begin
        if (SRST) begin
            armed_r <= 1'b0;
        end else if (ctl_wr) begin
            armed_r <= WB_DAT_I[CTL_KEY_MSB:CTL_KEY_LSB] == KEY_FIRST && !busy_r;
        end else if (take) begin
            armed_r <= 1'b0;
        end
    end

    // Data pointer, both bytes when byte lane 1 is selected, else the low byte only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ptr_r <= '0;
        end else if (wr_take && reg_is(WB_ADR_I, REG_PTR)) begin
            if (WB_SEL_I[1]) begin
                ptr_r <= WB_DAT_I[15:0];
            end else begin
                ptr_r[7:0] <= WB_DAT_I[7:0];
            end
        end
    end

    // Unmapped stores pass to normal data memory as a pulse
    always_ff @(posedge CLK) begin
        if (SRST) begin
            dwe_r   <= 1'b0;
            daddr_r <= '0;
            ddata_r <= '0;
        end else begin
            dwe_r <= store_wr && !latch_hit;
            if (store_wr && !latch_hit) begin
                daddr_r <= ptr_r;
                ddata_r <= WB_DAT_I[7:0];
            end
        end
    end

    // --------------------
    // Program sequencer: walk the page, erase then write loaded bytes
    // --------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
            job_r   <= SPC_USER;
            idx_r   <= '0;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (launch) begin
                        state_r <= ST_ERASE;
                        busy_r  <= 1'b1;
                        job_r   <= WB_DAT_I[CTL_SPC_MSB:CTL_SPC_LSB];
                        idx_r   <= '0;
                        cnt_r   <= 16'(ERASE_CYCLES) - 16'h0001;
                    end
                end
                ST_ERASE: begin
                    if (!lat_rloaded) begin
                        if (last_idx) begin
                            state_r <= ST_IDLE;
                            busy_r  <= 1'b0;
                        end else begin
                            idx_r <= idx_r + PAGE_AW'(1);
                            cnt_r <= wait_cyc - 16'h0001;
                        end
                    end else if (cnt_r == 16'h0000) begin
                        state_r <= ST_WRITE;
                        cnt_r   <= 16'(WRITE_CYCLES) - 16'h0001;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                ST_WRITE: begin
                    if (cnt_r != 16'h0000) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end else if (last_idx) begin
                        state_r <= ST_IDLE;
                        busy_r  <= 1'b0;
                    end else begin
                        state_r <= ST_ERASE;
                        idx_r   <= idx_r + PAGE_AW'(1);
                        cnt_r   <= 16'(ERASE_CYCLES) - 16'h0001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

    // Array update: erase marks erased, write stores latch byte
    always_ff @(posedge CLK) begin
        if (lat_rloaded && cnt_r == 16'h0000) begin
            if (job_r == SPC_USER && state_r != ST_IDLE) begin
                user_mem_r[{lat_page[4:0], idx_r}] <=
                    (state_r == ST_ERASE) ? ERASED_BYTE : lat_rdata;
            end
            if (job_r == SPC_BOOT_INFO_ROW && state_r != ST_IDLE) begin
                boot_info_row_mem_r[idx_r] <= (state_r == ST_ERASE) ? ERASED_BYTE : lat_rdata;
            end
        end
    end

    // Security byte: upper nibble by sequencer, lower nibble by pins only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sec_r <= SEC_RESET;
        end else begin
            if (job_r == SPC_SEC && lat_rloaded && cnt_r == 16'h0000) begin
                if (state_r == ST_ERASE) begin
                    sec_r[7:4] <= ERASED_BYTE[7:4];
                end else if (state_r == ST_WRITE) begin
                    sec_r[7:4] <= lat_rdata[7:4] & SEC_SW_MASK[7:4];
                end
            end
            if (pin_q[4] && !pp_we_d) begin
                sec_r[3:0] <= pin_q[3:0];
            end
        end
    end

    // Protection levels seen by the parallel programmer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            wblk_r <= 1'b0;
            rblk_r <= 1'b0;
        end else begin
            wblk_r <= !(sec_r[LB1_BIT] && sec_r[LB0_BIT]);
            rblk_r <= !sec_r[LB1_BIT] && sec_r[LB0_BIT];
        end
    end

    assign WB_ACK_O            = ack_r;
    assign WB_DAT_O            = dat_r;
    assign DMEM_WE             = dwe_r;
    assign DMEM_ADDR           = daddr_r;
    assign DMEM_DATA           = ddata_r;
    assign PROGRAM_IN_PROGRESS = busy_r;
    assign PP_WRITE_BLOCK      = wblk_r;
    assign PP_READ_BLOCK       = rblk_r;
endmodule

/* File: pkg/fpc_pkg.sv */
// Constants shared by the flash program control block
package fpc_pkg;
    // --------------------
    // Geometry
    // --------------------
    localparam int          PAGE_BYTES   = 128;
    localparam int          USER_BYTES   = 4096;
    localparam int          PAGE_AW      = 7;
    localparam int          USER_AW      = 12;
    localparam logic [15:0] LATCH_LO_TOP = 16'h0FFF;
    localparam logic [15:0] BOOT_INFO_ROW_BASE    = 16'hFF80;
    localparam logic [15:0] SEC_ADDR     = 16'h0000;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
    // --------------------
    // Control register fields
    // --------------------
    localparam int          CTL_KEY_MSB  = 7;
    localparam int          CTL_KEY_LSB  = 4;
    localparam int          CTL_MAP_BIT  = 3;
    localparam int          CTL_SPC_MSB  = 2;
    localparam int          CTL_SPC_LSB  = 1;
    localparam int          CTL_BUSY_BIT = 0;
    localparam logic [3:0]  KEY_FIRST    = 4'h5;
    localparam logic [3:0]  KEY_SECOND   = 4'hA;
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic [1:0]  SPC_USER     = 2'h0;
    localparam logic [1:0]  SPC_BOOT_INFO_ROW     = 2'h1;
    localparam logic [1:0]  SPC_SEC      = 2'h2;
    localparam logic [1:0]  SPC_RSVD     = 2'h3;
    // --------------------
    // Security byte: software half, hardware half, lock bits
    // --------------------
    localparam logic [7:0]  SEC_RESET    = 8'hFF;
    localparam logic [7:0]  SEC_SW_MASK  = 8'hF0;
    localparam int          LB1_BIT      = 1;
    localparam int          LB0_BIT      = 0;
    // --------------------
    // Register map (byte addresses)
    // --------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_PTR      = 8'h04;
    localparam logic [7:0]  REG_STORE    = 8'h08;
    localparam logic [7:0]  REG_LOAD     = 8'h0C;
    localparam logic [7:0]  REG_SEC      = 8'h10;
    // --------------------
    // Timing
    // --------------------
    localparam int          CLK_MHZ      = 200;
    localparam int          ERASE_NS     = 1000;
    localparam int          WRITE_NS     = 1000;
    localparam int          ERASE_CYC    = (ERASE_NS * CLK_MHZ + 999) / 1000;
    localparam int          WRITE_CYC    = (WRITE_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} fpc_state_e;
endpackage

/* File: design/fpc_latch.sv */
// Column latch buffer: one page of bytes, load flags and target page
module fpc_latch
    import fpc_pkg::*;
#(
    parameter int DEPTH = PAGE_BYTES,
    parameter int AW    = PAGE_AW
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          wr,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [7:0]    wpage,
    input  wire logic          clear,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata,
    output logic               rloaded,
    output logic      [7:0]    page
);
    logic [7:0]       mem_r [DEPTH];
    logic [DEPTH-1:0] loaded_r;
    logic [7:0]       page_r;

    // Byte store, any count from one to a full page
    always_ff @(posedge clk) begin
        if (wr) begin
            mem_r[waddr] <= wdata;
        end
    end

    // Load flags mark which locations take part in the next program
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            loaded_r <= '0;
        end else if (wr) begin
            loaded_r[waddr] <= 1'b1;
        end
    end

    // Last loaded page selects the programming page
    always_ff @(posedge clk) begin
        if (srst) begin
            page_r <= '0;
        end else if (wr) begin
            page_r <= wpage;
        end
    end

    assign rdata   = mem_r[raddr];
    assign rloaded = loaded_r[raddr];
    assign page    = page_r;
endmodule

/* File: test/fpc_chk.sv */
// Port-level properties of the flash program control block
module fpc_chk
    import fpc_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int WRITE_CYCLES = WRITE_CYC
) (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        WB_ACK_O,
    input wire logic        DMEM_WE,
    input wire logic        PROGRAM_IN_PROGRESS,
    input wire logic        PP_WRITE_BLOCK,
    input wire logic        PP_READ_BLOCK
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAX_BUSY = 128 * (1 + ERASE_CYCLES + WRITE_CYCLES) + 8;
    logic        take;
    logic        ctl_wr;
    logic        go;
    logic        armed_r;
    logic [19:0] busy_cnt_r;
    logic        sec_job_r;
    // --------------------
    // Helper logic
    // --------------------
    // Taken request, control write, valid second key
    assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign ctl_wr = take && WB_WE_I && WB_ADR_I == REG_CTRL && WB_SEL_I[0];
    assign go     = ctl_wr && WB_DAT_I[7:4] == KEY_SECOND && WB_DAT_I[2:1] != SPC_RSVD
                    && armed_r && !PROGRAM_IN_PROGRESS;
    // Armed only when the last taken access was a first key
    always_ff @(posedge CLK) begin
        if (SRST) begin
            armed_r <= 1'b0;
        end else if (take) begin
            armed_r <= ctl_wr && WB_DAT_I[7:4] == KEY_FIRST && !PROGRAM_IN_PROGRESS;
        end
    end
    // Security job walks one slot only
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sec_job_r <= 1'b0;
        end else if (go) begin
            sec_job_r <= WB_DAT_I[2:1] == SPC_SEC;
        end
    end
    // Length of the current busy run
    always_ff @(posedge CLK) begin
        if (SRST || !PROGRAM_IN_PROGRESS) begin
            busy_cnt_r <= 20'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 20'h1;
        end
    end
    // --------------------
    // Properties
    // --------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    property p_ack_resp; take |=> WB_ACK_O; endproperty
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    property p_dmem; DMEM_WE |-> WB_ACK_O && $past(WB_WE_I && WB_ADR_I == REG_STORE); endproperty
    property p_launch; go |=> PROGRAM_IN_PROGRESS; endproperty
    property p_no_launch; take && !go && !PROGRAM_IN_PROGRESS |=> !PROGRAM_IN_PROGRESS; endproperty
    property p_busy_min;
        $fell(PROGRAM_IN_PROGRESS) && !sec_job_r |-> busy_cnt_r >= 20'h80;
    endproperty
    property p_busy_max; PROGRAM_IN_PROGRESS |-> busy_cnt_r < MAX_BUSY; endproperty
    property p_lock; PP_READ_BLOCK |-> PP_WRITE_BLOCK; endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("no ack after a taken request");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_dmem: assert property (p_dmem)
        else $error("data store pulse without a store access");
    a_launch: assert property (p_launch)
        else $error("key pair did not start programming");
    a_no_launch: assert property (p_no_launch)
        else $error("programming started without a key pair");
    a_busy_min: assert property (p_busy_min)
        else $error("busy shorter than one page pass");
    a_busy_max: assert property (p_busy_max)
        else $error("busy never cleared");
    a_lock: assert property (p_lock)
        else $error("read block without write block");
    c_launch: cover property (go);
    c_dmem: cover property (DMEM_WE);
    c_lock: cover property (PP_READ_BLOCK);
endmodule

bind fpc_top fpc_chk #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) i_chk (
    .CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .DMEM_WE(DMEM_WE), .PROGRAM_IN_PROGRESS(PROGRAM_IN_PROGRESS),
    .PP_WRITE_BLOCK(PP_WRITE_BLOCK), .PP_READ_BLOCK(PP_READ_BLOCK)
);

/* File: test/fpc_cpu_model.sv */
// CPU core model issuing classic Wishbone cycles to the block
module fpc_cpu_model
    import fpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdata,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic      [7:0]  adr,
    output logic      [3:0]  sel,
    output logic      [31:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle at time zero
    initial begin
        {cyc, stb, we, adr, sel, wdata} = '0;
    end
    // One cycle, held until ack, released lines inverted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdata} <= {2'b11, w, a, 4'hF, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdata;
        {cyc, stb, we, adr, wdata} <= {3'b000, ~a, ~d};
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h00000000, q);
    endtask
    // Store through the data pointer
    task automatic store(input logic [15:0] p, input logic [7:0] d);
        wr(REG_PTR, {16'h0000, p});
        wr(REG_STORE, {24'h000000, d});
    endtask
    // Key pair back to back, map bit held clear
    task automatic launch(input logic [1:0] s);
        wr(REG_CTRL, {24'h000000, KEY_FIRST, 1'b0, s, 1'b0});
        wr(REG_CTRL, {24'h000000, KEY_SECOND, 1'b0, s, 1'b0});
    endtask
    // Poll busy until it clears
    task automatic wait_done;
        logic [31:0] q;
        do rd(REG_CTRL, q); while (q[0] !== 1'b0);
    endtask
    // Map a space, code load at the pointer, unmap
    task automatic read_space(input logic [1:0] s, input logic [15:0] p,
                              output logic [31:0] q);
        wr(REG_CTRL, {24'h000000, 4'h0, 1'b0, s, 1'b0});
        wr(REG_PTR, {16'h0000, p});
        rd(REG_LOAD, q);
        wr(REG_CTRL, 32'h00000000);
    endtask
endmodule

/* File: test/tb_fpc_top.sv */
// Self-checking bench for the flash program control block
module tb_fpc_top
    import fpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        dmem_we;
    logic [15:0] dmem_addr;
    logic [7:0]  dmem_data;
    logic        busy;
    logic        pp_we = 1'b0;
    logic [3:0]  pp_lo = 4'h0;
    logic        wblk;
    logic        rblk;
    logic [31:0] d;
    int          num_errors = 0;
    int          checks_done = 0;
    int          dmem_cnt = 0;
    logic [3:0]  pin_val [4] = '{4'hE, 4'hD, 4'hC, 4'hF};
    logic [1:0]  blk_exp [4] = '{2'b01, 2'b11, 2'b01, 2'b00};
    // --------------------
    // Clock, design, partner
    // --------------------
    always #2.5 clk = ~clk;
    fpc_top #(.ERASE_CYCLES(2), .WRITE_CYCLES(2)) i_dut (
        .CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdata), .WB_DAT_O(rdata),
        .WB_ACK_O(ack), .DMEM_WE(dmem_we), .DMEM_ADDR(dmem_addr), .DMEM_DATA(dmem_data),
        .PROGRAM_IN_PROGRESS(busy), .PP_SEC_WE(pp_we), .PP_SEC_LO(pp_lo),
        .PP_WRITE_BLOCK(wblk), .PP_READ_BLOCK(rblk)
    );
    fpc_cpu_model i_cpu (.clk(clk), .ack(ack), .rdata(rdata), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .wdata(wdata));
    // Count plain data stores
    always @(posedge clk) begin
        if (dmem_we === 1'b1) begin
            dmem_cnt <= dmem_cnt + 1;
        end
    end
    // --------------------
    // Compare and closing tasks
    // --------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [1:0] s, input logic [15:0] p, input logic [7:0] e);
        logic [31:0] q;
        i_cpu.read_space(s, p, q);
        chk(q, {24'h000000, e});
    endtask
    task automatic end_sim;
        $display("Errors: %0d, checks: %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    // --------------------
    // Test sequence
    // --------------------
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        i_cpu.rd(REG_CTRL, d);
        chk(d, 32'h00000000);
        i_cpu.rd(REG_SEC, d);
        chk(d, 32'h000000FF);
        i_cpu.rd(8'h3C, d);
        chk(d, 32'h00000000);
        chk({30'h0, rblk, wblk}, 32'h00000000);
        // Unmapped store goes to data memory
        i_cpu.store(16'h0123, 8'h5A);
        i_cpu.wr(REG_CTRL, 32'h00000008);
        chk({8'h00, dmem_addr, dmem_data}, 32'h0001235A);
        // Single byte, then a partial page across two pages
        i_cpu.store(16'h0087, 8'h22);
        i_cpu.wr(REG_CTRL, 32'h00000000);
        i_cpu.launch(SPC_USER);
        i_cpu.wr(REG_CTRL, 32'h00000000);
        i_cpu.rd(REG_CTRL, d);
        chk(d, 32'h00000001);
        i_cpu.wait_done();
        i_cpu.wr(REG_CTRL, 32'h00000008);
        i_cpu.store(16'h0010, 8'h11);
        i_cpu.store(16'h0085, 8'h3C);
        i_cpu.store(16'h0086, 8'h7E);
        i_cpu.wr(REG_CTRL, 32'h00000000);
        chk(32'(dmem_cnt), 32'h00000001);
        i_cpu.launch(SPC_USER);
        i_cpu.wait_done();
        rchk(SPC_USER, 16'h0085, 8'h3C);
        rchk(SPC_USER, 16'h0086, 8'h7E);
        rchk(SPC_USER, 16'h0090, 8'h11);
        rchk(SPC_USER, 16'h0087, 8'h22);
        // Broken key pair and reserved space
        i_cpu.wr(REG_CTRL, 32'h00000050);
        i_cpu.rd(REG_CTRL, d);
        i_cpu.wr(REG_CTRL, 32'h000000A0);
        i_cpu.launch(SPC_RSVD);
        i_cpu.rd(REG_CTRL, d);
        chk(d, 32'h000000A6);
        // Extra row
        i_cpu.wr(REG_CTRL, 32'h00000008);
        i_cpu.store(16'hFF85, 8'h44);
        i_cpu.launch(SPC_BOOT_INFO_ROW);
        i_cpu.wait_done();
        rchk(SPC_BOOT_INFO_ROW, 16'hFF85, 8'h44);
        rchk(SPC_BOOT_INFO_ROW, 16'h0085, 8'hFF);
        // Security byte: only the upper half from software
        i_cpu.wr(REG_CTRL, 32'h0000000C);
        i_cpu.store(16'h0000, 8'h5A);
        i_cpu.launch(SPC_SEC);
        i_cpu.wait_done();
        rchk(SPC_SEC, 16'h0000, 8'h5F);
        rchk(SPC_RSVD, 16'h0000, 8'hFF);
        // Lock levels through the parallel pins
        for (int i = 0; i < 4; i++) begin
            pp_lo <= pin_val[i];
            @(posedge clk);
            pp_we <= 1'b1;
            repeat (10) @(posedge clk);
            pp_we <= 1'b0;
            repeat (10) @(posedge clk);
            chk({30'h0, rblk, wblk}, {30'h0, blk_exp[i]});
            i_cpu.rd(REG_SEC, d);
            chk(d, {24'h000000, 4'h5, pin_val[i]});
        end
        i_cpu.wr(REG_SEC, 32'h00000000);
        i_cpu.rd(REG_SEC, d);
        chk(d, 32'h0000005F);
        end_sim();
    end
endmodule
